// [rtl/sfg_pkg.sv]
// Purpose: Shared constants and types for the sensor front end GPIO and power control.
// Assumes: 200 MHz system clock standing in for the gated internal oscillator.
// Notes:   All offsets, field positions and reset values live here.
package sfg_pkg;

   // ==========================================================
   // Register map
   localparam logic [7:0] SFG_OFF_PORT_OUT  = 8'h40;
   localparam logic [7:0] SFG_OFF_PORT_IN   = 8'h41;
   localparam logic [7:0] SFG_OFF_PIN_MODE  = 8'h70;

   localparam int         SFG_PORT_W        = 2;
   localparam int         SFG_DATA_LSB      = 0;
   localparam int         SFG_DIR_LSB       = 4;
   localparam int         SFG_MODE_REF_OUT  = 0;
   localparam int         SFG_MODE_REF_IN   = 1;
   localparam int         SFG_MODE_PF_OFF   = 2;
   localparam int         SFG_MODE_PF_ON    = 3;

   localparam logic [1:0] SFG_DIR_RST       = 2'h3;
   localparam logic [1:0] SFG_DATA_RST      = 2'h0;
   localparam logic [7:0] SFG_RD_ZERO       = 8'h00;

   // ==========================================================
   // Timing
   localparam int         SFG_CLK_MHZ       = 200;
   localparam int         SFG_OSC_MHZ       = 4;
   localparam int         SFG_BOOT_MAX_US   = 800;
   localparam int         SFG_WAKE_MAX_US   = 450;
   localparam int         SFG_BOOT_CYC      = SFG_BOOT_MAX_US * SFG_CLK_MHZ;
   localparam int         SFG_WAKE_CYC      = SFG_WAKE_MAX_US * SFG_CLK_MHZ;
   localparam int         SFG_OSC_DIV       = SFG_CLK_MHZ / SFG_OSC_MHZ;
   localparam logic [5:0] SFG_OSC_DIV_LAST  = 6'(SFG_OSC_DIV - 1);
   localparam int         SFG_DIV_W         = 4;
   localparam int         SFG_TMR_W         = 20;

   // ==========================================================
   // Fuse layout: trim word, bus address, then calibration words
   localparam int         SFG_CAL_N         = 4;
   localparam logic [3:0] SFG_FUSE_TRIM     = 4'h0;
   localparam logic [3:0] SFG_FUSE_ADDR     = 4'h1;
   localparam logic [3:0] SFG_FUSE_LAST     = 4'(SFG_CAL_N + 1);

   // ==========================================================
   // Power sequence, Gray coded along boot, sleep, wake, active
   typedef enum logic [2:0] {
      SFG_BOOT   = 3'h0,
      SFG_TRIM   = 3'h1,
      SFG_CAL    = 3'h3,
      SFG_SLEEP  = 3'h2,
      SFG_WAKE   = 3'h6,
      SFG_ACTIVE = 3'h7
   } sfg_state_t;

   typedef struct packed {
      logic                  ref_out;
      logic                  ref_in;
      logic                  force_off;
      logic                  force_on;
   } sfg_mode_t;

   typedef struct packed {
      sfg_state_t                   fsm;
      logic [SFG_TMR_W-1:0]         tmr;
      logic [3:0]                   fuse_idx;
      logic [7:0]                   trim;
      logic [6:0]                   bus_addr;
      logic [SFG_CAL_N-1:0][7:0]    cal;
      logic [SFG_PORT_W-1:0]        out_data;
      logic [SFG_PORT_W-1:0]        dir;
      sfg_mode_t                    mode;
      logic [7:0]                   rdata;
      logic                         osc_ready;
      logic [5:0]                   pre;
      logic [SFG_DIV_W-1:0]         div;
      logic [SFG_DIV_W-1:0]         div_tick;
      logic [15:0]                  result;
      logic                         result_valid;
      logic                         conv_start;
   } sfg_top_st_t;

   typedef struct packed {
      logic [2:0]            ff1;
      logic [2:0]            ff2;
      logic [2:0]            ff3;
      logic [2:0]            q;
   } sfg_sync_st_t;

endpackage

// [rtl/sfg_pin_sync.sv]
// Purpose: Three-stage synchroniser for pin levels with agreement check.
// Assumes: Inputs are asynchronous to clk.
// Notes:   No filtering beyond the agreement of stages two and three.
module sfg_pin_sync
   import sfg_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic [2:0]  d,
   output logic      [2:0]  q
);

   sfg_sync_st_t st;
   sfg_sync_st_t next_st;

   // ==========================================================
   // Stage chain
   always_comb begin
      next_st     = st;
      next_st.ff1 = d;
      next_st.ff2 = st.ff1;
      next_st.ff3 = st.ff2;
      if (st.ff2 == st.ff3) begin
         next_st.q = st.ff3;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign q = st.q;

   property p_sync_agree;
      @(posedge clk) disable iff (!rst_n)
      (q != $past(q)) |-> ($past(st.ff2) == $past(st.ff3) && q == $past(st.ff3));
   endproperty
   a_sync_agree: assert property (p_sync_agree) else $error("pin level changed without agreement");

endmodule

// [rtl/sfg_top.sv]
// Purpose: GPIO port, pin function and charge pump control, oscillator power sequence.
// Assumes: Bus engine delivers decoded register reads and writes on clk.
// Notes:   Analog switches are driven by level outputs; no analog modelled here.
module sfg_top
   import sfg_pkg::*;
#(
   parameter int BOOT_CYC = SFG_BOOT_CYC,
   parameter int WAKE_CYC = SFG_WAKE_CYC
)(
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  ce,
   input  wire logic [7:0]            reg_addr,
   input  wire logic [7:0]            reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [7:0]            reg_rdata,
   input  wire logic                  bus_transaction_ok,
   input  wire logic                  sleep_req,
   input  wire logic [SFG_PORT_W-1:0] pin_in,
   output logic      [SFG_PORT_W-1:0] pin_out,
   output logic      [SFG_PORT_W-1:0] pin_oe,
   output logic                       ref_output_on_pin0,
   output logic                       ref_input_on_pin1,
   input  wire logic                  battery_low,
   output logic                       pump_enable,
   output logic                       pump_passthrough,
   output logic                       osc_enable,
   output logic                       osc_ready,
   output logic [SFG_DIV_W-1:0]       clk_div_tick,
   output logic                       fuse_req,
   output logic [3:0]                 fuse_addr,
   input  wire logic [7:0]            fuse_data,
   input  wire logic                  fuse_ack,
   output logic [7:0]                 trim_value,
   output logic [6:0]                 bus_default_addr,
   output logic [SFG_CAL_N*8-1:0]     cal_words,
   input  wire logic                  conv_req,
   output logic                       conv_start,
   input  wire logic [3:0]            enable_word,
   output logic                       modulator_on,
   output logic [2:0]                 stage_bypass,
   input  wire logic [15:0]           raw_code,
   input  wire logic                  raw_valid,
   output logic [15:0]                conversion_result,
   output logic                       result_valid
);

   sfg_top_st_t st;
   sfg_top_st_t next_st;
   logic [2:0]  sync_q;
   logic [1:0]  pin_level;
   logic        batt_low_s;

   // ==========================================================
   // Pin and comparator sampling
   sfg_pin_sync u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .ce    (ce),
      .d     ({battery_low, pin_in}),
      .q     (sync_q)
   );

   assign pin_level  = sync_q[1:0];
   assign batt_low_s = sync_q[2];

   function automatic logic [7:0] rd_decode(input logic [7:0] a, input sfg_top_st_t s, input logic [1:0] lv);
      logic [7:0] v;
      v = SFG_RD_ZERO;
      if (a == SFG_OFF_PORT_OUT) begin
         v[SFG_DATA_LSB +: SFG_PORT_W] = s.out_data;
         v[SFG_DIR_LSB +: SFG_PORT_W]  = s.dir;
      end else if (a == SFG_OFF_PORT_IN) begin
         v[SFG_DATA_LSB +: SFG_PORT_W] = lv;
      end else if (a == SFG_OFF_PIN_MODE) begin
         v[SFG_MODE_REF_OUT] = s.mode.ref_out;
         v[SFG_MODE_REF_IN]  = s.mode.ref_in;
         v[SFG_MODE_PF_OFF]  = s.mode.force_off;
         v[SFG_MODE_PF_ON]   = s.mode.force_on;
      end
      return v;
   endfunction

   // ==========================================================
   // Next state
   always_comb begin
      next_st              = st;
      next_st.conv_start   = 1'b0;
      next_st.result_valid = 1'b0;
      next_st.div_tick     = '0;

      // Input register ignores writes
      if (reg_wr) begin
         if (reg_addr == SFG_OFF_PORT_OUT) begin
            next_st.out_data = reg_wdata[SFG_DATA_LSB +: SFG_PORT_W];
            next_st.dir      = reg_wdata[SFG_DIR_LSB +: SFG_PORT_W];
         end else if (reg_addr == SFG_OFF_PIN_MODE) begin
            next_st.mode.ref_out   = reg_wdata[SFG_MODE_REF_OUT];
            next_st.mode.ref_in    = reg_wdata[SFG_MODE_REF_IN];
            next_st.mode.force_off = reg_wdata[SFG_MODE_PF_OFF];
            next_st.mode.force_on  = reg_wdata[SFG_MODE_PF_ON];
         end
      end
      if (reg_rd) begin
         next_st.rdata = rd_decode(reg_addr, st, pin_level);
      end

      // Oscillator prescaler and divider chain, cleared while asleep
      if (st.fsm != SFG_SLEEP) begin
         if (st.pre == SFG_OSC_DIV_LAST) begin
            next_st.pre = '0;
            next_st.div = st.div + 1'b1;
            // Each stage ticks when its own and all lower divider bits are set
            next_st.div_tick[0] = st.div[0];
            for (int i = 1; i < SFG_DIV_W; i++) begin
               next_st.div_tick[i] = next_st.div_tick[i-1] & st.div[i];
            end
         end else begin
            next_st.pre = st.pre + 1'b1;
         end
      end else begin
         next_st.pre = '0;
         next_st.div = '0;
      end

      case (st.fsm)
         SFG_BOOT: begin
            next_st.tmr      = SFG_TMR_W'(st.tmr + 1'b1);
            next_st.fuse_idx = SFG_FUSE_TRIM;
            next_st.fsm      = SFG_TRIM;
         end
         SFG_TRIM, SFG_CAL: begin
            next_st.tmr = SFG_TMR_W'(st.tmr + 1'b1);
            if (fuse_ack) begin
               if (st.fuse_idx == SFG_FUSE_TRIM) begin
                  next_st.trim = fuse_data;
                  next_st.fsm  = SFG_CAL;
               end else if (st.fuse_idx == SFG_FUSE_ADDR) begin
                  next_st.bus_addr = fuse_data[6:0];
               end else begin
                  next_st.cal[st.fuse_idx - SFG_FUSE_ADDR - 4'h1] = fuse_data;
               end
               next_st.fuse_idx = st.fuse_idx + 4'h1;
            end
            // Missing fuse answers must not hold the chip awake
            if ((fuse_ack && st.fuse_idx == SFG_FUSE_LAST) || int'(st.tmr) >= BOOT_CYC - 1) begin
               next_st.fsm = SFG_SLEEP;
               next_st.tmr = '0;
            end
         end
         SFG_SLEEP: begin
            next_st.osc_ready = 1'b0;
            next_st.tmr       = '0;
            if (bus_transaction_ok) begin
               next_st.fsm = SFG_WAKE;
            end
         end
         SFG_WAKE: begin
            next_st.tmr = SFG_TMR_W'(st.tmr + 1'b1);
            if (int'(st.tmr) >= WAKE_CYC - 1) begin
               next_st.fsm       = SFG_ACTIVE;
               next_st.osc_ready = 1'b1;
               next_st.tmr       = '0;
            end
         end
         SFG_ACTIVE: begin
            if (sleep_req) begin
               next_st.fsm       = SFG_SLEEP;
               next_st.osc_ready = 1'b0;
            end
         end
         default: begin
            next_st.fsm = SFG_SLEEP;
         end
      endcase

      // Start needs a running oscillator and a powered modulator
      if (conv_req && st.osc_ready && st.fsm == SFG_ACTIVE && enable_word[0]) begin
         next_st.conv_start = 1'b1;
      end

      // Raw code is offset binary around mid scale
      if (raw_valid) begin
         next_st.result       = {~raw_code[15], raw_code[14:0]};
         next_st.result_valid = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st          <= '0;
         st.fsm      <= SFG_BOOT;
         st.dir      <= SFG_DIR_RST;
         st.out_data <= SFG_DATA_RST;
      end else if (ce) begin
         st <= next_st;
      end
   end

   // ==========================================================
   // Outputs
   assign pin_out            = st.out_data;
   assign pin_oe[0]          = st.dir[0] & ~st.mode.ref_out;
   assign pin_oe[1]          = st.dir[1] & ~st.mode.ref_in;
   assign ref_output_on_pin0 = st.mode.ref_out;
   assign ref_input_on_pin1  = st.mode.ref_in;
   assign pump_enable        = st.mode.force_on | (~st.mode.force_off & batt_low_s);
   assign pump_passthrough   = ~pump_enable;
   assign osc_enable         = (st.fsm != SFG_SLEEP);
   assign osc_ready          = st.osc_ready;
   assign clk_div_tick       = st.div_tick;
   assign fuse_req           = (st.fsm == SFG_TRIM) || (st.fsm == SFG_CAL);
   assign fuse_addr          = st.fuse_idx;
   assign trim_value         = st.trim;
   assign bus_default_addr   = st.bus_addr;
   assign cal_words          = st.cal;
   assign reg_rdata          = st.rdata;
   assign conv_start         = st.conv_start;
   assign modulator_on       = enable_word[0];
   assign stage_bypass       = ~enable_word[3:1];
   assign conversion_result  = st.result;
   assign result_valid       = st.result_valid;

   // ==========================================================
   // Checks
   property p_hiz_dir0;
      @(posedge clk) disable iff (!rst_n)
      !st.dir[0] |-> !pin_oe[0];
   endproperty
   a_hiz_dir0: assert property (p_hiz_dir0) else $error("pin zero driven with direction zero");

   property p_dir_write;
      @(posedge clk) disable iff (!rst_n)
      (reg_wr && ce && reg_addr == SFG_OFF_PORT_OUT) |=>
         (st.dir == $past(reg_wdata[SFG_DIR_LSB +: SFG_PORT_W]) &&
          pin_out == $past(reg_wdata[SFG_DATA_LSB +: SFG_PORT_W]));
   endproperty
   a_dir_write: assert property (p_dir_write) else $error("port register write not applied");

   property p_ref_bypass;
      @(posedge clk) disable iff (!rst_n)
      ref_input_on_pin1 |-> !pin_oe[1];
   endproperty
   a_ref_bypass: assert property (p_ref_bypass) else $error("pin one driven in reference mode");

   property p_force_on;
      @(posedge clk) disable iff (!rst_n)
      st.mode.force_on |-> (pump_enable && !pump_passthrough);
   endproperty
   a_force_on: assert property (p_force_on) else $error("pump off despite force on");

   property p_force_off;
      @(posedge clk) disable iff (!rst_n)
      (st.mode.force_off && !st.mode.force_on) |-> (!pump_enable && pump_passthrough);
   endproperty
   a_force_off: assert property (p_force_off) else $error("pump on despite force off");

   property p_no_start_waking;
      @(posedge clk) disable iff (!rst_n)
      conv_start |-> ($past(st.fsm) == SFG_ACTIVE && $past(st.osc_ready));
   endproperty
   a_no_start_waking: assert property (p_no_start_waking) else $error("conversion started before ready");

   property p_sleep_not_ready;
      @(posedge clk) disable iff (!rst_n)
      (st.fsm == SFG_SLEEP && $past(st.fsm) == SFG_SLEEP) |-> !osc_ready;
   endproperty
   a_sleep_not_ready: assert property (p_sleep_not_ready) else $error("ready flag set while asleep");

   property p_wake_bound;
      @(posedge clk) disable iff (!rst_n)
      st.fsm == SFG_WAKE |-> int'(st.tmr) < WAKE_CYC;
   endproperty
   a_wake_bound: assert property (p_wake_bound) else $error("wake sequence too long");

   property p_boot_bound;
      @(posedge clk) disable iff (!rst_n)
      (st.fsm == SFG_TRIM || st.fsm == SFG_CAL) |-> int'(st.tmr) < BOOT_CYC;
   endproperty
   a_boot_bound: assert property (p_boot_bound) else $error("boot sequence too long");

   property p_twos;
      @(posedge clk) disable iff (!rst_n)
      (raw_valid && ce) |=> (conversion_result == {~$past(raw_code[15]), $past(raw_code[14:0])} && result_valid);
   endproperty
   a_twos: assert property (p_twos) else $error("result not two's complement");

endmodule

// [tb/sfg_host_model.sv]
// Purpose: Host side model driving decoded register, wake, sleep and conversion requests.
// Assumes: Requests change 1 ns after a rising edge and are taken on the next edge.
// Notes:   A conversion request during restart is only made when the caller overrides.
module sfg_host_model
   import sfg_pkg::*;
(
   input  wire logic       clk,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       osc_ready,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic            bus_transaction_ok,
   output logic            sleep_req,
   output logic            conv_req
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      reg_addr           = 8'h00;
      reg_wdata          = 8'h00;
      reg_wr             = 1'b0;
      reg_rd             = 1'b0;
      bus_transaction_ok = 1'b0;
      sleep_req          = 1'b0;
      conv_req           = 1'b0;
   end

   // ==========================================================
   // Register cycles
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(posedge clk);
      #1;
      reg_wr    = 1'b0;
      // Stale data would hide a missed strobe
      reg_wdata = ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_rd   = 1'b1;
      @(posedge clk);
      #1;
      reg_rd   = 1'b0;
      d        = reg_rdata;
   endtask

   // ==========================================================
   // Power and conversion requests
   task automatic strobe(input bit to_sleep);
      @(posedge clk);
      #1;
      if (to_sleep) sleep_req = 1'b1;
      else bus_transaction_ok = 1'b1;
      @(posedge clk);
      #1;
      sleep_req          = 1'b0;
      bus_transaction_ok = 1'b0;
   endtask

   task automatic conv_try(input bit override);
      if (osc_ready !== 1'b1 && !override) return;
      @(posedge clk);
      #1;
      conv_req = 1'b1;
      @(posedge clk);
      #1;
      conv_req = 1'b0;
   endtask
endmodule

// [tb/tb_top.sv]
// Purpose: Self-checking bench for port, pin function, pump and power sequencing.
// Assumes: Shortened boot and wake counts; fuse source answers every other cycle.
// Notes:   Pin levels are resolved from the driver enable and an external level.
module tb_top;
   import sfg_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int BOOT_N = 200;
   localparam int WAKE_N = 100;
   logic        clk, rst_n, ce, reg_wr, reg_rd, bus_transaction_ok, sleep_req, battery_low;
   logic        ref_output_on_pin0, ref_input_on_pin1, pump_enable, pump_passthrough;
   logic        osc_enable, osc_ready, fuse_req, fuse_ack, conv_req, conv_start, modulator_on;
   logic        raw_valid, result_valid;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, fuse_data, trim_value, rd;
   logic [1:0]  pin_in, pin_out, pin_oe, ext_level;
   logic [3:0]  clk_div_tick, fuse_addr, enable_word;
   logic [6:0]  bus_default_addr;
   logic [31:0] cal_words;
   logic [2:0]  stage_bypass;
   logic [15:0] raw_code, conversion_result;
   int          bad_count, checked, starts, fcnt;

   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);

   sfg_top #(.BOOT_CYC(BOOT_N), .WAKE_CYC(WAKE_N)) i_dut (.clk, .rst_n, .ce, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .bus_transaction_ok, .sleep_req, .pin_in, .pin_out, .pin_oe,
      .ref_output_on_pin0, .ref_input_on_pin1, .battery_low, .pump_enable, .pump_passthrough,
      .osc_enable, .osc_ready, .clk_div_tick, .fuse_req, .fuse_addr, .fuse_data, .fuse_ack,
      .trim_value, .bus_default_addr, .cal_words, .conv_req, .conv_start, .enable_word,
      .modulator_on, .stage_bypass, .raw_code, .raw_valid, .conversion_result, .result_valid);

   sfg_host_model i_host (.clk, .reg_rdata, .osc_ready, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .bus_transaction_ok, .sleep_req, .conv_req);

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ==========================================================
   // Fuse source and monitors
   always @(posedge clk) begin
      #1;
      if (fuse_req === 1'b1 && fcnt == 1) begin
         fuse_ack  = 1'b1;
         fuse_data = 8'ha0 + 8'(fuse_addr);
         fcnt      = 0;
      end else begin
         fuse_ack  = 1'b0;
         fuse_data = ~fuse_data;
         fcnt      = (fuse_req === 1'b1) ? fcnt + 1 : 0;
      end
   end

   // Mid-cycle sample keeps clear of the launching edge
   always @(negedge clk) if (conv_start === 1'b1) starts++;

   // ==========================================================
   // Compare and closing
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask

   task automatic chk_bit(input logic ok, input string what);
      checked++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("[FAIL] %0t %s", $time, what);
      end
   endtask

   task automatic summarize;
      if (bad_count == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset;
      chk_val(pin_oe, SFG_DIR_RST, "reset dir");
      chk_val(pin_out, SFG_DATA_RST, "reset data");
      chk_bit(osc_enable === 1'b1 && osc_ready === 1'b0, "boot osc");
      i_host.rd(SFG_OFF_PORT_OUT, rd);
      chk_val(rd, {2'h0, SFG_DIR_RST, 2'h0, SFG_DATA_RST}, "reset port reg");
      i_host.rd(SFG_OFF_PIN_MODE, rd);
      chk_val(rd, 8'h00, "reset mode reg");
   endtask

   task automatic t_boot;
      int n;
      n = 0;
      while (osc_enable === 1'b1 && n < BOOT_N + 10) begin
         tick(1);
         n++;
      end
      chk_bit(osc_enable === 1'b0 && n < BOOT_N, "boot to sleep");
      chk_val(trim_value, 8'ha0, "trim");
      chk_val(bus_default_addr, 7'h21, "address");
      chk_val(cal_words, 32'ha5a4a3a2, "cal");
      tick(20);
      chk_bit(osc_enable === 1'b0 && osc_ready === 1'b0, "stays asleep");
   endtask

   task automatic t_wake;
      int n;
      int s0;
      enable_word = 4'h1;
      i_host.strobe(1'b0);
      chk_bit(osc_enable === 1'b1, "wake osc");
      s0 = starts;
      n  = 0;
      fork
         i_host.conv_try(1'b1);
      join_none
      while (osc_ready !== 1'b1 && n < WAKE_N + 10) begin
         tick(1);
         n++;
      end
      chk_bit(n >= WAKE_N - 1 && n <= WAKE_N + 1, "wake time");
      chk_val(starts - s0, 0, "start in restart");
      i_host.conv_try(1'b0);
      tick(3);
      chk_val(starts - s0, 1, "start when ready");
      enable_word = 4'h0;
      i_host.conv_try(1'b0);
      tick(3);
      chk_val(starts - s0, 1, "start when off");
   endtask

   task automatic t_gpio;
      i_host.wr(SFG_OFF_PORT_OUT, 8'h11);
      chk_val(pin_oe, 2'h1, "dir per pin");
      chk_val(pin_out[0], 1'b1, "data drive");
      ext_level = 2'h2;
      tick(5);
      i_host.rd(SFG_OFF_PORT_IN, rd);
      chk_val(rd, 8'h03, "levels");
      ext_level = 2'h1;
      i_host.wr(SFG_OFF_PORT_OUT, 8'h10);
      tick(4);
      i_host.rd(SFG_OFF_PORT_IN, rd);
      chk_val(rd, 8'h00, "driven readback");
      i_host.wr(SFG_OFF_PORT_IN, 8'hff);
      i_host.rd(SFG_OFF_PORT_OUT, rd);
      chk_val(rd, 8'h10, "input reg write");
      i_host.rd(8'h55, rd);
      chk_val(rd, 8'h00, "unmapped read");
      i_host.wr(SFG_OFF_PORT_OUT, 8'h03);
      chk_val(pin_oe, 2'h0, "input only");
      tick(5);
      i_host.rd(SFG_OFF_PORT_IN, rd);
      chk_val(rd, 8'h01, "undriven levels");
      i_host.wr(SFG_OFF_PORT_OUT, 8'h30);
   endtask

   task automatic t_mode;
      logic e;
      i_host.wr(SFG_OFF_PIN_MODE, 8'h01);
      chk_bit(ref_output_on_pin0 === 1'b1 && pin_oe === 2'h2, "ref out");
      i_host.wr(SFG_OFF_PIN_MODE, 8'h02);
      chk_bit(ref_input_on_pin1 === 1'b1 && pin_oe === 2'h1, "ref in");
      for (int j = 0; j < 8; j++) begin
         battery_low = j[2];
         i_host.wr(SFG_OFF_PIN_MODE, {4'h0, j[1], j[0], 2'h0});
         tick(4);
         e = j[1] | (~j[0] & j[2]);
         chk_val(pump_enable, e, "pump");
         chk_val(pump_passthrough, 1'(~e), "pass");
      end
      i_host.rd(SFG_OFF_PIN_MODE, rd);
      chk_val(rd, 8'h0c, "mode readback");
      i_host.wr(SFG_OFF_PIN_MODE, 8'h00);
   endtask

   task automatic t_conv;
      logic [15:0] c;
      for (int k = 0; k < 4; k++) begin
         c = (k[0] ? 16'h7fff : 16'h0000) ^ (k[1] ? 16'h8000 : 16'h0000);
         raw_code  = c;
         raw_valid = 1'b1;
         tick(1);
         chk_bit(result_valid === 1'b1, "result pulse");
         chk_val(conversion_result, c ^ 16'h8000, "result");
      end
      raw_valid = 1'b0;
      tick(1);
      chk_bit(result_valid === 1'b0, "result pulse end");
      for (int i = 0; i < 16; i++) begin
         enable_word = 4'(i);
         tick(1);
         chk_val(modulator_on, i[0], "modulator");
         chk_val(stage_bypass, 3'(~i[3:1]), "bypass");
      end
   endtask

   task automatic t_div;
      int n;
      for (int b = 0; b < SFG_DIV_W; b++) begin
         n = 0;
         while (clk_div_tick[b] !== 1'b1 && n < 1000) begin
            tick(1);
            n++;
         end
         n = 0;
         do begin
            tick(1);
            n++;
         end while (clk_div_tick[b] !== 1'b1 && n < 1000);
         chk_val(n, SFG_OSC_DIV * (2 << b), "divider");
      end
   endtask

   task automatic t_sleep;
      i_host.strobe(1'b1);
      tick(1);
      chk_bit(osc_ready === 1'b0 && osc_enable === 1'b0, "back to sleep");
   endtask

   initial begin
      ce          = 1'b1;
      rst_n       = 1'b0;
      battery_low = 1'b0;
      ext_level   = 2'h0;
      enable_word = 4'h0;
      raw_code    = 16'h0000;
      raw_valid   = 1'b0;
      fuse_ack    = 1'b0;
      fuse_data   = 8'h00;
      fcnt        = 0;
      bad_count   = 0;
      checked     = 0;
      starts      = 0;
      repeat (12) @(posedge clk);
      #1;
      rst_n = 1'b1;
      t_reset;
      t_boot;
      t_wake;
      t_gpio;
      t_mode;
      t_conv;
      t_div;
      t_sleep;
      summarize;
   end

   // Whole run is a few thousand cycles
   initial begin
      #40000;
      bad_count++;
      summarize;
   end
endmodule
